// [ce_pkg.sv]
// constants shared by the carrier and eye event register block
package ce_pkg;
   // register offsets
   localparam logic [7:0] CE_ADDR_RSVD_A = 8'h51;
   localparam logic [7:0] CE_ADDR_BOOST = 8'h52;
   localparam logic [7:0] CE_ADDR_RSVD_B = 8'h53;
   localparam logic [7:0] CE_ADDR_STATUS = 8'h54;
   localparam logic [7:0] CE_ADDR_RSVD_C = 8'h55;
   localparam logic [7:0] CE_ADDR_ENABLE = 8'h56;
   localparam logic [7:0] CE_ADDR_RSVD_D = 8'h60;
   localparam logic [7:0] CE_ADDR_RSVD_E = 8'h61;
   localparam logic [7:0] CE_ADDR_RSVD_F = 8'h62;
   localparam logic [7:0] CE_ADDR_RSVD_G = 8'h63;
   localparam logic [7:0] CE_ADDR_RSVD_H = 8'h64;
   localparam logic [7:0] CE_ADDR_RSVD_I = 8'h65;
   localparam logic [7:0] CE_ADDR_RSVD_J = 8'h66;
   localparam logic [7:0] CE_ADDR_RSVD_K = 8'h67;
   localparam logic [7:0] CE_ADDR_RSVD_L = 8'h68;
   // reset values
   localparam logic [7:0] CE_RST_BOOST = 8'h00;
   localparam logic [7:0] CE_RST_STATUS = 8'h00;
   localparam logic [7:0] CE_RST_ENABLE = 8'h00;
   localparam logic [7:0] CE_RST_RSVD_A = 8'h00;
   localparam logic [7:0] CE_RST_RSVD_B = 8'h00;
   localparam logic [7:0] CE_RST_RSVD_C = 8'h02;
   localparam logic [7:0] CE_RST_RSVD_D = 8'h26;
   localparam logic [7:0] CE_RST_RSVD_E = 8'h31;
   localparam logic [7:0] CE_RST_RSVD_F = 8'h70;
   localparam logic [7:0] CE_RST_RSVD_G = 8'h3d;
   localparam logic [7:0] CE_RST_RSVD_H = 8'hff;
   localparam logic [7:0] CE_RST_RSVD_I = 8'h00;
   localparam logic [7:0] CE_RST_RSVD_J = 8'h00;
   localparam logic [7:0] CE_RST_RSVD_K = 8'h00;
   localparam logic [7:0] CE_RST_RSVD_L = 8'h00;
   localparam logic [7:0] CE_UNMAPPED_READ = 8'h00;
   // status and enable field positions
   localparam int CE_BIT_CARRIER_LIVE = 7;
   localparam int CE_BIT_LOCK_GAINED = 6;
   localparam int CE_BIT_IN1_FOUND = 5;
   localparam int CE_BIT_IN0_FOUND = 4;
   localparam int CE_BIT_EYE_REACHED = 3;
   localparam int CE_BIT_LOCK_LOST = 2;
   localparam int CE_BIT_IN1_LOST = 1;
   localparam int CE_BIT_IN0_LOST = 0;
   localparam int CE_NUM_EVENTS = 7;
   // positions in the level vector fed to the edge detector
   localparam int CE_LVL_IN0 = 0;
   localparam int CE_LVL_IN1 = 1;
   localparam int CE_LVL_LOCK = 2;
   localparam int CE_LVL_EYE = 3;
   localparam int CE_NUM_LEVELS = 4;
   // live carrier bit source selection
   localparam logic CE_SEL_CABLE = 1'b0;
endpackage

// [ce_edge_detect.sv]
// rise and fall pulse detector for a vector of level inputs
`timescale 1ns/1ns
module ce_edge_detect #(
   parameter int WIDTH = 4
) (
   input wire logic ref_clk, // block clock
   input wire logic srst, // synchronous reset, active high
   input wire logic [WIDTH-1:0] level_in, // levels to watch
   output logic [WIDTH-1:0] rise_pulse, // one cycle on a 0 to 1 step
   output logic [WIDTH-1:0] fall_pulse // one cycle on a 1 to 0 step
);
   logic [WIDTH-1:0] prev_reg;

   // previous sample; zero at reset so a level already high reports as found
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= level_in;
      end
   end

   // edges compare the present level with the last sample
   assign rise_pulse = level_in & ~prev_reg;
   assign fall_pulse = ~level_in & prev_reg;
endmodule

// [ce_event_flag.sv]
// one sticky event flag, cleared by a status read, set winning over clear
`timescale 1ns/1ns
module ce_event_flag (
   input wire logic ref_clk, // block clock
   input wire logic srst, // synchronous reset, active high
   input wire logic set_pulse, // event seen this cycle
   input wire logic clear_pulse, // status register read this cycle
   output logic flag_out // latched event flag
);
   logic flag_reg;
   logic flag_next;

   // a set in the clearing cycle survives so no event is lost
   assign flag_next = set_pulse | (flag_reg & ~clear_pulse);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag_out = flag_reg;
endmodule

// [ce_event_regs.sv]
// event status, event enable and boost readback registers with interrupt request
`timescale 1ns/1ns
module ce_event_regs
   import ce_pkg::*;
(
   input wire logic ref_clk, // block clock, 20 MHz
   input wire logic srst, // synchronous reset, active high
   input wire logic [7:0] reg_addr, // register offset
   input wire logic reg_wr_en, // write strobe, one cycle
   input wire logic [7:0] reg_wr_data, // write data
   input wire logic reg_rd_en, // read strobe, one cycle
   output logic [7:0] reg_rd_data, // read data, valid with reg_rd_valid
   output logic reg_rd_valid, // read answer, one cycle after strobe
   input wire logic cable_input_carrier, // carrier present on cable_input
   input wire logic trace_input_carrier, // carrier present on trace_input
   input wire logic input_select, // 0 selects cable_input, 1 trace_input
   input wire logic cdr_locked, // clock recovery locked level
   input wire logic eye_threshold_met, // eye opening at or above threshold
   input wire logic [7:0] adapted_boost_value, // boost chosen by adaptation
   output logic irq_req // interrupt request, active high level
);
   import ce_pkg::*;

   logic [7:0] boost_reg;
   logic [7:0] enable_reg;
   logic [7:0] enable_next;
   logic [7:0] rd_data_reg;
   logic rd_valid_reg;
   logic [CE_NUM_LEVELS-1:0] level_vec;
   logic [CE_NUM_LEVELS-1:0] rise_vec;
   logic [CE_NUM_LEVELS-1:0] fall_vec;
   logic [CE_NUM_EVENTS-1:0] event_set;
   logic [CE_NUM_EVENTS-1:0] event_flags;
   logic carrier_live;
   logic [7:0] status_view;
   logic [7:0] rd_mux;
   logic status_rd;
   logic enable_wr;
   logic [CE_NUM_EVENTS-1:0] gated_flags;

   // levels gathered for the shared edge detector
   assign level_vec[CE_LVL_IN0] = cable_input_carrier;
   assign level_vec[CE_LVL_IN1] = trace_input_carrier;
   assign level_vec[CE_LVL_LOCK] = cdr_locked;
   assign level_vec[CE_LVL_EYE] = eye_threshold_met;

   ce_edge_detect #(
      .WIDTH(CE_NUM_LEVELS)
   ) u_edges (
      .ref_clk(ref_clk),
      .srst(srst),
      .level_in(level_vec),
      .rise_pulse(rise_vec),
      .fall_pulse(fall_vec)
   );

   assign event_set[CE_BIT_LOCK_GAINED] = rise_vec[CE_LVL_LOCK];
   assign event_set[CE_BIT_IN1_FOUND] = rise_vec[CE_LVL_IN1];
   assign event_set[CE_BIT_IN0_FOUND] = rise_vec[CE_LVL_IN0];
   // eye threshold source; only the crossing counts, not the level
   assign event_set[CE_BIT_EYE_REACHED] = rise_vec[CE_LVL_EYE];
   assign event_set[CE_BIT_LOCK_LOST] = fall_vec[CE_LVL_LOCK];
   assign event_set[CE_BIT_IN1_LOST] = fall_vec[CE_LVL_IN1];
   assign event_set[CE_BIT_IN0_LOST] = fall_vec[CE_LVL_IN0];

   // any read of the status offset is the clear strobe
   assign status_rd = reg_rd_en && (reg_addr == CE_ADDR_STATUS);
   assign enable_wr = reg_wr_en && (reg_addr == CE_ADDR_ENABLE);

   // one sticky flag per event source
   genvar gi;
   generate
      for (gi = 0; gi < CE_NUM_EVENTS; gi++) begin : g_flag
         ce_event_flag u_flag (
            .ref_clk(ref_clk),
            .srst(srst),
            .set_pulse(event_set[gi]),
            .clear_pulse(status_rd),
            .flag_out(event_flags[gi])
         );
      end
   endgenerate

   // live carrier of whichever input is selected
   assign carrier_live = (input_select == CE_SEL_CABLE) ? cable_input_carrier : trace_input_carrier;
   // status is only assembled, never written
   assign status_view = {carrier_live, event_flags};

   // bit 7 stays zero; only the enable offset writes
   assign enable_next = enable_wr ? {1'b0, reg_wr_data[6:0]} : enable_reg;

   // enable register and boost capture
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         enable_reg <= CE_RST_ENABLE;
         boost_reg <= CE_RST_BOOST;
      end else begin
         enable_reg <= enable_next;
         boost_reg <= adapted_boost_value;
      end
   end

   // read decode; reserved offsets answer their reset pattern
   always_comb begin
      case (reg_addr)
         CE_ADDR_RSVD_A: rd_mux = CE_RST_RSVD_A;
         CE_ADDR_BOOST: rd_mux = boost_reg;
         CE_ADDR_RSVD_B: rd_mux = CE_RST_RSVD_B;
         CE_ADDR_STATUS: rd_mux = status_view;
         CE_ADDR_RSVD_C: rd_mux = CE_RST_RSVD_C;
         CE_ADDR_ENABLE: rd_mux = enable_reg;
         CE_ADDR_RSVD_D: rd_mux = CE_RST_RSVD_D;
         CE_ADDR_RSVD_E: rd_mux = CE_RST_RSVD_E;
         CE_ADDR_RSVD_F: rd_mux = CE_RST_RSVD_F;
         CE_ADDR_RSVD_G: rd_mux = CE_RST_RSVD_G;
         CE_ADDR_RSVD_H: rd_mux = CE_RST_RSVD_H;
         CE_ADDR_RSVD_I: rd_mux = CE_RST_RSVD_I;
         CE_ADDR_RSVD_J: rd_mux = CE_RST_RSVD_J;
         CE_ADDR_RSVD_K: rd_mux = CE_RST_RSVD_K;
         CE_ADDR_RSVD_L: rd_mux = CE_RST_RSVD_L;
         default: rd_mux = CE_UNMAPPED_READ;
      endcase
   end

   // read data is captured before the clear lands, so software sees the events
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= reg_rd_en;
         if (reg_rd_en) begin
            rd_data_reg <= rd_mux;
         end
      end
   end

   assign reg_rd_data = rd_data_reg;
   assign reg_rd_valid = rd_valid_reg;

   assign gated_flags[CE_BIT_LOCK_GAINED] = event_flags[CE_BIT_LOCK_GAINED] & enable_reg[CE_BIT_LOCK_GAINED];
   assign gated_flags[CE_BIT_IN1_FOUND] = event_flags[CE_BIT_IN1_FOUND] & enable_reg[CE_BIT_IN1_FOUND];
   assign gated_flags[CE_BIT_IN0_FOUND] = event_flags[CE_BIT_IN0_FOUND] & enable_reg[CE_BIT_IN0_FOUND];
   assign gated_flags[CE_BIT_EYE_REACHED] = event_flags[CE_BIT_EYE_REACHED] & enable_reg[CE_BIT_EYE_REACHED];
   assign gated_flags[CE_BIT_LOCK_LOST] = event_flags[CE_BIT_LOCK_LOST] & enable_reg[CE_BIT_LOCK_LOST];
   assign gated_flags[CE_BIT_IN1_LOST] = event_flags[CE_BIT_IN1_LOST] & enable_reg[CE_BIT_IN1_LOST];
   assign gated_flags[CE_BIT_IN0_LOST] = event_flags[CE_BIT_IN0_LOST] & enable_reg[CE_BIT_IN0_LOST];

   // enabled latched flags raise the request; live carrier never does
   // masking the flags rather than the events lets software arm an enable late and still see the request
   assign irq_req = |gated_flags;

   // checks on the observable behaviour
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence s_enable_write;
      enable_wr && !reg_rd_en;
   endsequence

   sequence s_enable_readback;
      reg_rd_en && (reg_addr == CE_ADDR_ENABLE) && !reg_wr_en;
   endsequence

   chk_boost_readback: assert property (
      (reg_rd_en && reg_addr == CE_ADDR_BOOST) |=> reg_rd_valid && reg_rd_data == $past(boost_reg))
      else $error("boost readback mismatch");

   // read with no new event empties flags
   chk_read_clears: assert property (
      (status_rd && event_set == '0) |=> event_flags == '0)
      else $error("status read did not clear flags");

   // bit 7 reflects the selected carrier
   chk_live_carrier: assert property (
      status_rd |=> reg_rd_data[CE_BIT_CARRIER_LIVE] ==
         ($past(input_select) ? $past(trace_input_carrier) : $past(cable_input_carrier)))
      else $error("live carrier bit wrong");

   chk_lock_gained: assert property (
      $rose(cdr_locked) |=> event_flags[CE_BIT_LOCK_GAINED])
      else $error("lock gain not flagged");

   chk_found_flags: assert property (
      ($rose(trace_input_carrier) |=> event_flags[CE_BIT_IN1_FOUND]) and
      ($rose(cable_input_carrier) |=> event_flags[CE_BIT_IN0_FOUND]))
      else $error("carrier found not flagged");

   chk_eye_reached: assert property (
      $rose(eye_threshold_met) |=> event_flags[CE_BIT_EYE_REACHED])
      else $error("eye threshold not flagged");

   chk_lock_lost: assert property (
      $fell(cdr_locked) |=> event_flags[CE_BIT_LOCK_LOST])
      else $error("lock loss not flagged");

   chk_lost_flags: assert property (
      ($fell(trace_input_carrier) |=> event_flags[CE_BIT_IN1_LOST]) and
      ($fell(cable_input_carrier) |=> event_flags[CE_BIT_IN0_LOST]))
      else $error("carrier loss not flagged");

   // reset clears state; checked through reset itself
   chk_reset_values: assert property (@(posedge ref_clk) disable iff (1'b0)
      srst |=> event_flags == '0 && enable_reg == CE_RST_ENABLE && boost_reg == CE_RST_BOOST && !irq_req)
      else $error("reset values wrong");

   // enable write then read returns data with bit 7 zero
   chk_enable_rw: assert property (
      s_enable_write ##1 !enable_wr ##1 s_enable_readback |=> reg_rd_data == ($past(reg_wr_data, 3) & 8'h7f))
      else $error("enable readback wrong");

   // disabled sources never raise the request
   chk_irq_masked: assert property (
      (enable_reg[CE_NUM_EVENTS-1:0] == '0) |-> !irq_req)
      else $error("request with all sources disabled");

   // an enabled event raises the request next cycle
   chk_irq_raised: assert property (
      (|(event_set & enable_reg[CE_NUM_EVENTS-1:0]) && !enable_wr) |=> irq_req)
      else $error("enabled event did not raise request");

   // flags hold while no read occurs
   chk_flag_holds: assert property (
      !status_rd |=> (event_flags & $past(event_flags)) == $past(event_flags))
      else $error("flag dropped without read");

   // event in the clearing cycle survives
   chk_set_wins: assert property (
      (status_rd && event_set != '0) |=> (event_flags & $past(event_set)) == $past(event_set))
      else $error("event lost during clear");

   // lock-loss enable alone gates only its own flag
   chk_lock_loss_gate: assert property (
      (enable_reg == (8'h01 << CE_BIT_LOCK_LOST)) |->
         irq_req == event_flags[CE_BIT_LOCK_LOST])
      else $error("lock loss gating wrong");

   // lock-gain enable alone gates only its own flag
   chk_lock_gain_gate: assert property (
      (enable_reg == (8'h01 << CE_BIT_LOCK_GAINED)) |->
         irq_req == event_flags[CE_BIT_LOCK_GAINED])
      else $error("lock gain gating wrong");

   // carrier found enables gate their own flags
   chk_found_gate: assert property (
      ((enable_reg == (8'h01 << CE_BIT_IN1_FOUND)) |-> irq_req == event_flags[CE_BIT_IN1_FOUND]) and
      ((enable_reg == (8'h01 << CE_BIT_IN0_FOUND)) |-> irq_req == event_flags[CE_BIT_IN0_FOUND]))
      else $error("carrier found gating wrong");

   // eye enable alone gates only its own flag
   chk_eye_gate: assert property (
      (enable_reg == (8'h01 << CE_BIT_EYE_REACHED)) |->
         irq_req == event_flags[CE_BIT_EYE_REACHED])
      else $error("eye threshold gating wrong");

   // carrier lost enables gate their own flags
   chk_lost_gate: assert property (
      ((enable_reg == (8'h01 << CE_BIT_IN1_LOST)) |-> irq_req == event_flags[CE_BIT_IN1_LOST]) and
      ((enable_reg == (8'h01 << CE_BIT_IN0_LOST)) |-> irq_req == event_flags[CE_BIT_IN0_LOST]))
      else $error("carrier lost gating wrong");

   // a write to the status offset leaves the flags alone
   chk_status_readonly: assert property (
      (reg_wr_en && reg_addr == CE_ADDR_STATUS && !status_rd && event_set == '0) |=>
         event_flags == $past(event_flags))
      else $error("status changed by a write");

   // writes elsewhere never touch the enables
   chk_enable_guarded: assert property (
      (reg_wr_en && reg_addr != CE_ADDR_ENABLE) |=> $stable(enable_reg))
      else $error("enable changed by a foreign write");
endmodule

// [tb.sv]
// self-checking testbench for the carrier and eye event register block
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic input_select = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wr_data = 8'h00;
   logic [7:0] boost = 8'h00;
   logic [3:0] lv = 4'h0; // cable, trace, lock, eye levels
   logic [7:0] reg_rd_data;
   logic reg_rd_valid;
   logic irq_req;
   logic [6:0] flg = 7'h00; // expected latched flags
   logic [6:0] en = 7'h00; // expected enables
   logic [31:0] r;
   integer n_fail = 0;
   integer checked = 0;
   integer seed = 32'h1f478d8e;
   integer i;
   integer k;
   // offsets and reset values, with two unmapped offsets that read zero
   logic [7:0] ra [0:16] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h60,
                              8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68};
   logic [7:0] rv [0:16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h26,
                              8'h31, 8'h70, 8'h3d, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   // level index and direction that raise each status bit 0..6
   int bi [0:6] = '{0, 1, 2, 3, 0, 1, 2};
   logic [6:0] bv = 7'b1111000;

   ce_event_regs u_ce_event_regs (
      .ref_clk(ref_clk),
      .srst(srst),
      .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en),
      .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid),
      .cable_input_carrier(lv[0]),
      .trace_input_carrier(lv[1]),
      .input_select(input_select),
      .cdr_locked(lv[2]),
      .eye_threshold_met(lv[3]),
      .adapted_boost_value(boost),
      .irq_req(irq_req)
   );

   // 20 MHz block clock
   always #25 ref_clk = ~ref_clk;

   // expected status: live carrier of the selected input over the latched flags
   function automatic logic [7:0] stat_exp();
      return {(input_select ? lv[1] : lv[0]), flg};
   endfunction

   // status bit raised by a step on one level; the eye has no falling event
   function automatic logic [7:0] ev_mask(input int idx, input logic rise);
      logic [7:0] up [0:3] = '{8'h10, 8'h20, 8'h40, 8'h08};
      logic [7:0] dn [0:3] = '{8'h01, 8'h02, 8'h04, 8'h00};
      return rise ? up[idx] : dn[idx];
   endfunction

   task automatic set_lvl(input int idx, input logic v);
      logic [7:0] m;
      @(posedge ref_clk);
      m = ev_mask(idx, v);
      if (lv[idx] !== v) flg = flg | m[6:0];
      lv[idx] <= v;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(irq_req, |(flg & en))
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      #1;
      `CHK(reg_rd_valid, 1'b1)
      `CHK(reg_rd_data, e)
      // a status read empties every latched flag, so the request must fall
      if (a == 8'h54) begin
         flg = 7'h00;
         @(posedge ref_clk);
         #1;
         `CHK(irq_req, 1'b0)
         `CHK(reg_rd_valid, 1'b0)
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      if (a == 8'h56) en = d[6:0];
      #1;
      `CHK(irq_req, |(flg & en))
   endtask

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog sized well above the roughly 1600 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      test_done();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      // reset values, reserved constants and unmapped reads
      for (i = 0; i < 17; i++) rd(ra[i], rv[i]);
      // writes outside the enable register must leave everything unchanged
      for (i = 0; i < 17; i++) if (ra[i] != 8'h56) wr(ra[i], 8'ha5);
      for (i = 0; i < 17; i++) rd(ra[i], rv[i]);
      // the reserved top enable bit reads back as zero
      wr(8'h56, 8'hff);
      rd(8'h56, 8'h7f);
      wr(8'h56, 8'h00);
      // each event alone: blocked by the others' enables, passed by its own
      for (k = 0; k < 7; k++) begin
         set_lvl(bi[k], !bv[k]);
         rd(8'h54, stat_exp());
         wr(8'h56, 8'h7f ^ (8'h01 << k));
         set_lvl(bi[k], bv[k]);
         wr(8'h56, 8'h01 << k);
         rd(8'h54, stat_exp());
         rd(8'h54, stat_exp());
      end
      // random mix of level steps, enables, selection and boost readback
      for (i = 0; i < 300; i++) begin
         r = $random(seed);
         case (r[1:0])
            2'd0: set_lvl(int'(r[3:2]), r[4]);
            2'd1: wr(8'h56, r[15:8]);
            2'd2: rd(8'h54, stat_exp());
            default: begin
               @(posedge ref_clk);
               input_select <= r[4];
               boost <= r[15:8];
               repeat (2) @(posedge ref_clk);
               rd(8'h52, boost);
               rd(8'h54, stat_exp());
            end
         endcase
      end
      // mid-run reset: enables and flags clear, levels already high come back as found
      wr(8'h56, 8'h7f);
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      en = 7'h00;
      flg = {lv[2], lv[1], lv[0], lv[3], 3'b000};
      #1;
      `CHK(irq_req, 1'b0)
      rd(8'h56, 8'h00);
      rd(8'h54, stat_exp());
      rd(8'h54, stat_exp());
      test_done();
   end
endmodule
